// ==== rtl/cpuam_consts.svh ====
// Constants for the addressing-mode decoder
// Function
// - Seventeen operand addressing modes in seven families are decoded.
// - Short modes other than the indexed ones reach page zero only; long modes reach the full 64 Kbyte space.
// - Read-modify-write opcodes decode to short or no-offset addressing modes only.
// - Inherent instructions are one byte; no operand byte is fetched.
// - Mask-set raises interrupt level to 3; mask-reset lowers it to 0.
// - Immediate instructions are two bytes; second byte is the operand value.
// - Direct short fetches one address byte, range 00 to FF.
// - Direct long fetches a two-byte address word, full 64 Kbyte range.
// - Indexed address is the unsigned sum of index and offset.
// - Indexed without offset fetches nothing; address is the index, 00 to FF.
// - Indexed short fetches one offset byte; sum covers 00 to 1FE.
// - Indexed long fetches a two-byte offset word; sum reaches 64 Kbyte.
// - Indirect: byte after opcode addresses a pointer read from memory.
// - Indirect short reads a one-byte page-zero pointer; one byte follows opcode.
// - Indirect long reads a two-byte page-zero pointer; one byte follows opcode.
// - Relative branches add a signed 8-bit offset to the program counter.
// - Indirect indexed adds the index, unsigned, to the fetched pointer.
// - Prefix 90 selects the second index register instead of the first.
`ifndef CPUAM_CONSTS_SVH
`define CPUAM_CONSTS_SVH

// Prefix bytes
`define CPUAM_PFX_ALT_IDX 8'h90
`define CPUAM_PFX_IND_ALT 8'h91
`define CPUAM_PFX_IND 8'h92

// Inherent interrupt-mask opcodes
`define CPUAM_OP_MASK_SET 8'h9b
`define CPUAM_OP_MASK_CLR 8'h9a

// Interrupt levels
`define CPUAM_LVL_MASKED 2'h3
`define CPUAM_LVL_OPEN 2'h0
`define CPUAM_LVL_RESET 2'h3

// Opcode high-nibble groups
`define CPUAM_GRP_BITREL 4'h0
`define CPUAM_GRP_BIT 4'h1
`define CPUAM_GRP_REL 4'h2
`define CPUAM_GRP_RMW_DIR 4'h3
`define CPUAM_GRP_RMW_IDX1 4'h6
`define CPUAM_GRP_RMW_IDX0 4'h7
`define CPUAM_GRP_IMM 4'ha
`define CPUAM_GRP_DIR1 4'hb
`define CPUAM_GRP_DIR2 4'hc
`define CPUAM_GRP_IDX2 4'hd
`define CPUAM_GRP_IDX1 4'he
`define CPUAM_GRP_IDX0 4'hf

// Reset counter value and page-zero high byte
`define CPUAM_PC_RESET 16'h0000
`define CPUAM_PAGE_ZERO 8'h00

`endif

// ==== rtl/cpuam_pkg.sv ====
// Types for the addressing-mode decoder
package cpuam_pkg;

   typedef enum logic [4:0] {
      am_inherent, am_immediate, am_dir_short, am_dir_long,
      am_idx_none, am_idx_short, am_idx_long,
      am_ind_short, am_ind_long, am_indidx_short, am_indidx_long,
      am_rel_direct, am_rel_indirect,
      am_bit_direct, am_bit_indirect, am_bitrel_direct, am_bitrel_indirect
   } cpuam_mode_t;

   typedef enum logic [2:0] {
      st_idle, st_op, st_b1, st_b2, st_p1, st_p2, st_rel
   } cpuam_state_t;

   typedef struct packed {
      cpuam_state_t st;
      cpuam_mode_t mode;
      logic [15:0] pc;
      logic [15:0] ea;
      logic [15:0] target;
      logic [7:0] operand;
      logic [7:0] opcode;
      logic [7:0] b1;
      logic use_y;
      logic ind;
      logic [15:0] mem_addr;
      logic mem_rd;
      logic done;
      logic branch;
      logic [1:0] int_level;
   } cpuam_regs_t;

endpackage

// ==== rtl/cpuam_mode_dec.sv ====
// Opcode group to addressing-mode decoder
`timescale 1ns/1ps
`include "cpuam_consts.svh"
module cpuam_mode_dec (
   // Opcode and indirect prefix
   input wire logic [7:0] opcode,
   input wire logic ind,
   // Decoded mode
   output cpuam_pkg::cpuam_mode_t mode
);

   // Group nibble selects the mode; indirect prefix swaps to pointer form
   always_comb begin
      unique case (opcode[7:4])
         `CPUAM_GRP_IMM: mode = cpuam_pkg::am_immediate;
         `CPUAM_GRP_DIR1: mode = ind ? cpuam_pkg::am_ind_short : cpuam_pkg::am_dir_short;
         `CPUAM_GRP_DIR2: mode = ind ? cpuam_pkg::am_ind_long : cpuam_pkg::am_dir_long;
         `CPUAM_GRP_IDX2: mode = ind ? cpuam_pkg::am_indidx_long : cpuam_pkg::am_idx_long;
         `CPUAM_GRP_IDX1: mode = ind ? cpuam_pkg::am_indidx_short : cpuam_pkg::am_idx_short;
         `CPUAM_GRP_IDX0: mode = cpuam_pkg::am_idx_none;
         // Read-modify-write groups never take a long form
         `CPUAM_GRP_RMW_DIR: mode = ind ? cpuam_pkg::am_ind_short : cpuam_pkg::am_dir_short;
         `CPUAM_GRP_RMW_IDX1: begin
            mode = ind ? cpuam_pkg::am_indidx_short : cpuam_pkg::am_idx_short;
         end
         `CPUAM_GRP_RMW_IDX0: mode = cpuam_pkg::am_idx_none;
         `CPUAM_GRP_REL: mode = ind ? cpuam_pkg::am_rel_indirect : cpuam_pkg::am_rel_direct;
         `CPUAM_GRP_BIT: mode = ind ? cpuam_pkg::am_bit_indirect : cpuam_pkg::am_bit_direct;
         `CPUAM_GRP_BITREL: begin
            mode = ind ? cpuam_pkg::am_bitrel_indirect : cpuam_pkg::am_bitrel_direct;
         end
         default: mode = cpuam_pkg::am_inherent;
      endcase
   end

endmodule

// ==== rtl/cpuam_top.sv ====
// Addressing-mode sequencer and effective-address generator
`timescale 1ns/1ps
`include "cpuam_consts.svh"
module cpuam_top (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Control
   input wire logic start,
   input wire logic pc_load,
   input wire logic [15:0] pc_load_val,
   // Index registers
   input wire logic [7:0] idx_x,
   input wire logic [7:0] idx_y,
   // Memory bus
   output logic [15:0] mem_addr,
   output logic mem_rd,
   input wire logic [7:0] mem_rdata,
   // Results
   output logic done,
   output cpuam_pkg::cpuam_mode_t mode,
   output logic [7:0] opcode,
   output logic [15:0] ea,
   output logic [7:0] operand,
   output logic branch,
   output logic [15:0] target,
   output logic [15:0] pc,
   output logic [1:0] int_level
);

   cpuam_pkg::cpuam_regs_t s_q;
   cpuam_pkg::cpuam_regs_t s_d;
   cpuam_pkg::cpuam_mode_t dec_mode;

   // Mode of the byte now on the bus
   cpuam_mode_dec u_dec (
      .opcode(mem_rdata),
      .ind(s_q.ind),
      .mode(dec_mode)
   );

   // Selected index register, widened to an address
   function automatic logic [15:0] sel_idx(input logic use_y, input logic [7:0] x,
                                           input logic [7:0] y);
      sel_idx = {`CPUAM_PAGE_ZERO, use_y ? y : x};
   endfunction

   // Signed 8-bit offset widened for the counter
   function automatic logic [15:0] sext(input logic [7:0] v);
      sext = {{8{v[7]}}, v};
   endfunction

   // Read the next program byte and step the counter
   function automatic cpuam_pkg::cpuam_regs_t fetch(input cpuam_pkg::cpuam_regs_t r);
      fetch = r;
      fetch.mem_addr = r.pc;
      fetch.mem_rd = 1'b1;
      fetch.pc = r.pc + 16'h0001;
   endfunction

   // Read a page-zero pointer byte
   function automatic cpuam_pkg::cpuam_regs_t rd_zp(input cpuam_pkg::cpuam_regs_t r,
                                                    input logic [7:0] a);
      rd_zp = r;
      rd_zp.mem_addr = {`CPUAM_PAGE_ZERO, a};
      rd_zp.mem_rd = 1'b1;
   endfunction

   // Close the sequence with an address
   function automatic cpuam_pkg::cpuam_regs_t finish(input cpuam_pkg::cpuam_regs_t r,
                                                     input logic [15:0] a);
      finish = r;
      finish.ea = a;
      finish.done = 1'b1;
      finish.st = cpuam_pkg::st_idle;
   endfunction

   // Next-state logic
   always_comb begin
      s_d = s_q;
      s_d.done = 1'b0;
      s_d.mem_rd = 1'b0;
      unique case (s_q.st)
         cpuam_pkg::st_idle: begin
            if (pc_load) begin
               s_d.pc = pc_load_val;
            end
            if (start) begin
               s_d.use_y = 1'b0;
               s_d.ind = 1'b0;
               s_d.branch = 1'b0;
               s_d.operand = 8'h00;
               s_d = fetch(s_d);
               s_d.st = cpuam_pkg::st_op;
            end
         end
         cpuam_pkg::st_op: begin
            if (mem_rdata == `CPUAM_PFX_ALT_IDX) begin
               s_d.use_y = 1'b1;
               s_d = fetch(s_d);
            end else if (mem_rdata == `CPUAM_PFX_IND_ALT) begin
               s_d.use_y = 1'b1;
               s_d.ind = 1'b1;
               s_d = fetch(s_d);
            end else if (mem_rdata == `CPUAM_PFX_IND) begin
               s_d.ind = 1'b1;
               s_d = fetch(s_d);
            end else begin
               s_d.opcode = mem_rdata;
               s_d.mode = dec_mode;
               if (dec_mode == cpuam_pkg::am_inherent) begin
                  // Opcode alone; no operand fetch
                  if (mem_rdata == `CPUAM_OP_MASK_SET) begin
                     s_d.int_level = `CPUAM_LVL_MASKED;
                  end else if (mem_rdata == `CPUAM_OP_MASK_CLR) begin
                     s_d.int_level = `CPUAM_LVL_OPEN;
                  end
                  s_d = finish(s_d, s_q.ea);
               end else if (dec_mode == cpuam_pkg::am_idx_none) begin
                  s_d = finish(s_d, sel_idx(s_q.use_y, idx_x, idx_y));
               end else begin
                  s_d = fetch(s_d);
                  s_d.st = cpuam_pkg::st_b1;
               end
            end
         end
         cpuam_pkg::st_b1: begin
            s_d.b1 = mem_rdata;
            unique case (s_q.mode)
               cpuam_pkg::am_immediate: begin
                  s_d.operand = mem_rdata;
                  s_d = finish(s_d, s_q.ea);
               end
               cpuam_pkg::am_dir_short, cpuam_pkg::am_bit_direct: begin
                  s_d = finish(s_d, {`CPUAM_PAGE_ZERO, mem_rdata});
               end
               cpuam_pkg::am_bitrel_direct: begin
                  s_d.ea = {`CPUAM_PAGE_ZERO, mem_rdata};
                  s_d = fetch(s_d);
                  s_d.st = cpuam_pkg::st_rel;
               end
               cpuam_pkg::am_dir_long, cpuam_pkg::am_idx_long: begin
                  s_d = fetch(s_d);
                  s_d.st = cpuam_pkg::st_b2;
               end
               cpuam_pkg::am_idx_short: begin
                  // Unsigned sum reaches 1fe at most
                  s_d = finish(s_d, {`CPUAM_PAGE_ZERO, mem_rdata} +
                               sel_idx(s_q.use_y, idx_x, idx_y));
               end
               cpuam_pkg::am_rel_direct: begin
                  s_d.target = s_q.pc + sext(mem_rdata);
                  s_d.branch = 1'b1;
                  s_d = finish(s_d, s_q.ea);
               end
               default: begin
                  // Byte after opcode is a pointer address
                  s_d = rd_zp(s_d, mem_rdata);
                  s_d.st = cpuam_pkg::st_p1;
               end
            endcase
         end
         cpuam_pkg::st_b2: begin
            if (s_q.mode == cpuam_pkg::am_idx_long) begin
               s_d = finish(s_d, {s_q.b1, mem_rdata} +
                            sel_idx(s_q.use_y, idx_x, idx_y));
            end else begin
               s_d = finish(s_d, {s_q.b1, mem_rdata});
            end
         end
         cpuam_pkg::st_p1: begin
            s_d.b1 = mem_rdata;
            unique case (s_q.mode)
               cpuam_pkg::am_ind_long, cpuam_pkg::am_indidx_long: begin
                  // Second pointer byte, still in page zero
                  s_d = rd_zp(s_d, s_q.b1 + 8'h01);
                  s_d.st = cpuam_pkg::st_p2;
               end
               cpuam_pkg::am_indidx_short: begin
                  s_d = finish(s_d, {`CPUAM_PAGE_ZERO, mem_rdata} +
                               sel_idx(s_q.use_y, idx_x, idx_y));
               end
               cpuam_pkg::am_bitrel_indirect: begin
                  s_d.ea = {`CPUAM_PAGE_ZERO, mem_rdata};
                  s_d = fetch(s_d);
                  s_d.st = cpuam_pkg::st_rel;
               end
               cpuam_pkg::am_rel_indirect: begin
                  s_d.target = s_q.pc + sext(mem_rdata);
                  s_d.branch = 1'b1;
                  s_d = finish(s_d, s_q.ea);
               end
               default: begin
                  s_d = finish(s_d, {`CPUAM_PAGE_ZERO, mem_rdata});
               end
            endcase
         end
         cpuam_pkg::st_p2: begin
            if (s_q.mode == cpuam_pkg::am_indidx_long) begin
               s_d = finish(s_d, {s_q.b1, mem_rdata} +
                            sel_idx(s_q.use_y, idx_x, idx_y));
            end else begin
               s_d = finish(s_d, {s_q.b1, mem_rdata});
            end
         end
         cpuam_pkg::st_rel: begin
            s_d.target = s_q.pc + sext(mem_rdata);
            s_d.branch = 1'b1;
            s_d = finish(s_d, s_q.ea);
         end
         default: begin
            s_d.st = cpuam_pkg::st_idle;
         end
      endcase
   end

   // State register
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_q <= '0;
         s_q.st <= cpuam_pkg::st_idle;
         s_q.mode <= cpuam_pkg::am_inherent;
         s_q.pc <= `CPUAM_PC_RESET;
         s_q.int_level <= `CPUAM_LVL_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from the state register
   assign mem_addr = s_q.mem_addr;
   assign mem_rd = s_q.mem_rd;
   assign done = s_q.done;
   assign mode = s_q.mode;
   assign opcode = s_q.opcode;
   assign ea = s_q.ea;
   assign operand = s_q.operand;
   assign branch = s_q.branch;
   assign target = s_q.target;
   assign pc = s_q.pc;
   assign int_level = s_q.int_level;

endmodule

// ==== tb/cpuam_properties.sv ====
// Concurrent checks on the addressing-mode decoder ports
`timescale 1ns/1ps
module cpuam_properties (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Memory bus
   input wire logic [15:0] mem_addr,
   input wire logic mem_rd,
   input wire logic [7:0] mem_rdata,
   // Results
   input wire logic done,
   input wire cpuam_pkg::cpuam_mode_t mode,
   input wire logic [7:0] opcode,
   input wire logic [15:0] ea,
   input wire logic [7:0] operand,
   input wire logic [15:0] pc,
   input wire logic [1:0] int_level
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);

   // Completion follows the last byte read
   chk_done_after_read: assert property (done |-> $past(mem_rd) && !mem_rd)
      else $error("done without preceding read");
   chk_done_single: assert property (done |=> !done)
      else $error("done longer than one cycle");
   chk_inh_length: assert property (done && mode == cpuam_pkg::am_inherent
      |-> pc == $past(mem_addr) + 16'h0001)
      else $error("inherent fetched beyond opcode");
   chk_mask_set: assert property (done && opcode == 8'h9b |-> int_level == 2'h3)
      else $error("mask set level wrong");
   chk_mask_clear: assert property (done && opcode == 8'h9a |-> int_level == 2'h0)
      else $error("mask clear level wrong");
   chk_imm_value: assert property (done && mode == cpuam_pkg::am_immediate
      |-> operand == $past(mem_rdata))
      else $error("immediate operand wrong");
   chk_short_page: assert property (done && (mode inside {cpuam_pkg::am_dir_short,
      cpuam_pkg::am_idx_none, cpuam_pkg::am_ind_short}) |-> ea[15:8] == 8'h00)
      else $error("short mode left page zero");
   chk_idx_reach: assert property (done && mode == cpuam_pkg::am_idx_short
      |-> ea <= 16'h01fe)
      else $error("indexed short out of range");
   chk_ptr_page: assert property (done && (mode inside {cpuam_pkg::am_ind_short,
      cpuam_pkg::am_ind_long, cpuam_pkg::am_indidx_short, cpuam_pkg::am_indidx_long})
      |-> $past(mem_addr) < 16'h0100)
      else $error("pointer read outside page zero");
   chk_long_word: assert property (done && (mode == cpuam_pkg::am_dir_long
      || mode == cpuam_pkg::am_ind_long)
      |-> ea == {$past(mem_rdata, 2), $past(mem_rdata)})
      else $error("long address word wrong");
endmodule

// ==== tb/cpuam_mem_model.sv ====
// Memory model on the far side of the decoder's bus
`timescale 1ns/1ps
module cpuam_mem_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Memory bus
   input wire logic [15:0] mem_addr,
   input wire logic mem_rd,
   output logic [7:0] mem_rdata
);
   logic [7:0] m [0:65535];
   logic [7:0] last_q;
   // Data valid only with the strobe; inverted stale value otherwise
   assign mem_rdata = mem_rd ? m[mem_addr] : ~last_q;
   // Remember last byte served
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         last_q <= 8'h00;
      end else if (mem_rd) begin
         last_q <= m[mem_addr];
      end
   end
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the addressing-mode decoder
`timescale 1ns/1ps
module tb;
   typedef struct {
      logic [31:0] prog;
      int len;
      int nrd;
      cpuam_pkg::cpuam_mode_t mode;
      logic [15:0] res;
   } cpuam_row_t;
   logic clk, rstn, start, pc_load, mem_rd, done, branch;
   logic [15:0] pc_load_val, mem_addr, ea, target, pc;
   logic [7:0] idx_x, idx_y, mem_rdata, opcode, operand;
   logic [1:0] int_level;
   cpuam_pkg::cpuam_mode_t mode;
   cpuam_row_t rows [22];
   int failures = 0;
   int num_checks = 0;
   int cyc = 0;
   int nr;

   cpuam_top dut (.clk(clk), .rstn(rstn), .start(start), .pc_load(pc_load),
      .pc_load_val(pc_load_val), .idx_x(idx_x), .idx_y(idx_y), .mem_addr(mem_addr),
      .mem_rd(mem_rd), .mem_rdata(mem_rdata), .done(done), .mode(mode), .opcode(opcode),
      .ea(ea), .operand(operand), .branch(branch), .target(target), .pc(pc),
      .int_level(int_level));
   cpuam_mem_model u_mem (.clk(clk), .rstn(rstn), .mem_addr(mem_addr), .mem_rd(mem_rd),
      .mem_rdata(mem_rdata));

   // Clock, 50 ns period
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         failures++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, cyc, 0);
         complete_run();
      end
   end

   task automatic complete_run();
      if (failures == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Program bytes placed at 0200
   task automatic load(input logic [31:0] p);
      for (int j = 0; j < 4; j++) begin
         u_mem.m[16'h0200 + j] = p[31 - 8 * j -: 8];
      end
   endtask

   // One decode from 0200; counts reads until done
   task automatic run(output int n);
      int k;
      n = 0;
      k = 0;
      @(negedge clk);
      pc_load = 1'b1;
      pc_load_val = 16'h0200;
      @(negedge clk);
      pc_load = 1'b0;
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      while (done !== 1'b1 && k < 20) begin
         if (mem_rd === 1'b1) n++;
         k++;
         @(negedge clk);
      end
      check({15'h0000, done}, 16'h0001);
   endtask

   function automatic logic [15:0] res_of(input cpuam_pkg::cpuam_mode_t md);
      case (md)
         cpuam_pkg::am_inherent: res_of = {14'h0000, int_level};
         cpuam_pkg::am_immediate: res_of = {8'h00, operand};
         cpuam_pkg::am_rel_direct, cpuam_pkg::am_rel_indirect: res_of = target;
         default: res_of = ea;
      endcase
   endfunction

   // Relative and bit-relative modes yield a branch target
   function automatic logic [15:0] br_of(input cpuam_pkg::cpuam_mode_t md);
      br_of = 16'(md inside {cpuam_pkg::am_rel_direct, cpuam_pkg::am_rel_indirect,
                             cpuam_pkg::am_bitrel_direct, cpuam_pkg::am_bitrel_indirect});
   endfunction

   initial begin
      rstn = 1'b0;
      start = 1'b0;
      pc_load = 1'b0;
      pc_load_val = 16'h0000;
      idx_x = 8'hff;
      idx_y = 8'h07;
      u_mem.m[16'h0010] = 8'h34;
      u_mem.m[16'h0011] = 8'h56;
      rows = '{
         '{32'h9a000000, 1, 1, cpuam_pkg::am_inherent, 16'h0000},
         '{32'h9d000000, 1, 1, cpuam_pkg::am_inherent, 16'h0000},
         '{32'h9b000000, 1, 1, cpuam_pkg::am_inherent, 16'h0003},
         '{32'ha6550000, 2, 2, cpuam_pkg::am_immediate, 16'h0055},
         '{32'hb6100000, 2, 2, cpuam_pkg::am_dir_short, 16'h0010},
         '{32'h3c100000, 2, 2, cpuam_pkg::am_dir_short, 16'h0010},
         '{32'hc6123400, 3, 3, cpuam_pkg::am_dir_long, 16'h1234},
         '{32'hf6000000, 1, 1, cpuam_pkg::am_idx_none, 16'h00ff},
         '{32'he6ff0000, 2, 2, cpuam_pkg::am_idx_short, 16'h01fe},
         '{32'hd6120000, 3, 3, cpuam_pkg::am_idx_long, 16'h12ff},
         '{32'h90e61000, 3, 3, cpuam_pkg::am_idx_short, 16'h0017},
         '{32'h92b61000, 3, 4, cpuam_pkg::am_ind_short, 16'h0034},
         '{32'h92c61000, 3, 5, cpuam_pkg::am_ind_long, 16'h3456},
         '{32'h92e61000, 3, 4, cpuam_pkg::am_indidx_short, 16'h0133},
         '{32'h91d61000, 3, 5, cpuam_pkg::am_indidx_long, 16'h345d},
         '{32'h20050000, 2, 2, cpuam_pkg::am_rel_direct, 16'h0207},
         '{32'h20fb0000, 2, 2, cpuam_pkg::am_rel_direct, 16'h01fd},
         '{32'h00100300, 3, 3, cpuam_pkg::am_bitrel_direct, 16'h0010},
         '{32'h10100000, 2, 2, cpuam_pkg::am_bit_direct, 16'h0010},
         '{32'h92201000, 3, 4, cpuam_pkg::am_rel_indirect, 16'h0237},
         '{32'h92101100, 3, 4, cpuam_pkg::am_bit_indirect, 16'h0056},
         '{32'h92001105, 4, 5, cpuam_pkg::am_bitrel_indirect, 16'h0056}};
      repeat (20) @(negedge clk);
      rstn = 1'b1;
      // Table of ordinary decodes
      foreach (rows[i]) begin
         load(rows[i].prog);
         run(nr);
         check(16'(nr), 16'(rows[i].nrd));
         check({11'h000, mode}, {11'h000, rows[i].mode});
         check(res_of(rows[i].mode), rows[i].res);
         check(pc, 16'h0200 + 16'(rows[i].len));
         check({15'h0000, branch}, br_of(rows[i].mode));
      end
      // Bit-relative indirect target after the offset byte
      check(target, 16'h0209);
      // Open the mask so the later reset has a level to restore
      load(32'h9a000000);
      run(nr);
      check({14'h0000, int_level}, 16'h0000);
      // Counter load and start both refused while busy
      load(32'hc6123400);
      @(negedge clk);
      pc_load = 1'b1;
      pc_load_val = 16'h0200;
      @(negedge clk);
      pc_load = 1'b0;
      start = 1'b1;
      @(negedge clk);
      pc_load = 1'b1;
      pc_load_val = 16'h0f00;
      @(negedge clk);
      pc_load = 1'b0;
      start = 1'b0;
      repeat (4) @(negedge clk);
      check(pc, 16'h0203);
      check(ea, 16'h1234);
      // Reset in mid decode
      load(32'h92c61000);
      @(negedge clk);
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      rstn = 1'b0;
      @(negedge clk);
      check(pc, 16'h0000);
      check({14'h0000, int_level}, 16'h0003);
      check({11'h000, mode}, {11'h000, cpuam_pkg::am_inherent});
      rstn = 1'b1;
      load(32'ha6550000);
      run(nr);
      check({8'h00, operand}, 16'h0055);
      complete_run();
   end
endmodule

bind cpuam_top cpuam_properties u_chk (.clk(clk), .rstn(rstn), .mem_addr(mem_addr),
   .mem_rd(mem_rd), .mem_rdata(mem_rdata), .done(done), .mode(mode), .opcode(opcode),
   .ea(ea), .operand(operand), .pc(pc), .int_level(int_level));
